// ---- pkg/pei_consts.svh ----
// Offsets, field positions, reset values of the event interrupt registers
// Assumes inclusion by bare name from the design files
`ifndef PEI_CONSTS_SVH
`define PEI_CONSTS_SVH
// Register indices; byte address is four times the index
`define PEI_IDX_CTL    6'h11
`define PEI_IDX_A      6'h12
`define PEI_IDX_B      6'h13
// Reset values
`define PEI_CTL_RST    16'h0108
`define PEI_EVT_RST    16'h0000
// Writable bits of the control register
`define PEI_CTL_WMASK  16'hff1f
// Control bit positions
`define PEI_CTL_OUTEN  0
`define PEI_CTL_MIE    1
`define PEI_CTL_TEST   2
`define PEI_CTL_POL    3
// First register events, position in the pending byte
`define PEI_A_LQ       7
`define PEI_A_ED       6
`define PEI_A_LINK     5
`define PEI_A_SPEED    4
`define PEI_A_DUPLEX   3
`define PEI_A_ANDONE   2
`define PEI_A_FCHF     1
`define PEI_A_REHF     0
// Second register events, position in the pending byte
`define PEI_B_EEE      7
`define PEI_B_ANERR    6
`define PEI_B_PAGE     5
`define PEI_B_LOOPF    4
`define PEI_B_MDIX     3
`define PEI_B_SLEEP    2
`define PEI_B_POLWOL   1
`define PEI_B_JABBER   0
// Bus responses
`define PEI_RESP_OKAY  2'h0
`define PEI_RESP_SLV   2'h2
`endif

// ---- pkg/pei_pkg.sv ----
// Types shared by the event interrupt register block
// Assumes the consts header supplies all numeric values
package pei_pkg;
  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pei_wr_t;
  typedef struct packed {
    logic        en;
    logic [11:0] addr;
  } pei_rd_t;
endpackage

// ---- design/pei_axil_slave.sv ----
// AXI4-Lite slave front end for the event interrupt registers
// Assumes one outstanding write and one outstanding read at a time
`timescale 1ns/1ps
`include "pei_consts.svh"
module pei_axil_slave (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  // Write channels
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // Read channels
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Register side
  output pei_pkg::pei_wr_t      o_wr,
  output pei_pkg::pei_rd_t      o_rd,
  input  wire logic             i_wr_err,
  input  wire logic [31:0]      i_rd_data,
  input  wire logic             i_rd_err
);
  logic        aw_full_q;
  logic        w_full_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  wire         aw_take = s_axi_awvalid & ~aw_full_q;
  wire         w_take = s_axi_wvalid & ~w_full_q;
  wire         wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire         rd_fire = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign o_wr = '{en: wr_fire, addr: awaddr_q, data: wdata_q, strb: wstrb_q};
  assign o_rd = '{en: rd_fire, addr: s_axi_araddr};
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PEI_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= i_wr_err ? `PEI_RESP_SLV : `PEI_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `PEI_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= i_rd_err ? `PEI_RESP_SLV : `PEI_RESP_OKAY;
      rdata_q  <= i_rd_data;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// ---- design/pei_top.sv ----
// Event status and enable registers with interrupt pin control
// Assumes event inputs are one-cycle pulses synchronous to i_core_clk
//
// Contract
// [RULE1] First register bit 15 latches on link quality change, clears on read.
// [RULE2] First register bit 14 latches on energy detect change, clears on read.
// [RULE3] First register bit 13 latches on link status change, clears on read.
// [RULE4] First register bit 12 latches on speed change, clears on read.
// [RULE5] First register bit 11 latches on duplex change, clears on read.
// [RULE6] First register bit 10 latches on negotiation complete, clears on read.
// [RULE7] First register bit 9 latches on false carrier half-full, clears on read.
// [RULE8] First register bit 8 latches on receive error half-full, clears on read.
// [RULE9] First register bits 7..0 enable the status bit eight above.
// [RULE10] Second register bit 15 latches on efficient-Ethernet error, clears on read.
// [RULE11] Second register bit 14 latches on negotiation error, clears on read.
// [RULE12] Second register bit 13 latches on page received, clears on read.
// [RULE13] Second register bit 12 latches on loopback FIFO over/underflow.
// [RULE14] Second register bit 11 latches on crossover status change.
// [RULE15] Second register bit 10 latches on sleep mode event.
// [RULE16] Second register bit 9 latches on inverted polarity or wake packet.
// [RULE17] Second register bit 8 latches on jabber, clears on read.
// [RULE18] Second register bits 7..0 enable the status bit eight above.
// [RULE19] Second register sits at index 13h and resets to zero.
// [RULE20] Event interrupts need the control master enable bit 1.
// [RULE21] Control bit 3 selects pin polarity; reset one gives idle high.
// [RULE22] Control bit 0 makes the shared pin an interrupt output.
// [RULE23] Control bit 2 forces a continuous interrupt for testing.
// [RULE24] Request asserts while any enabled bit is pending, gated by master.
// [RULE25] Read clears returned bits; same-cycle event stays pending.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pei_consts.svh"
module pei_top (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event pulses
  input  wire logic [7:0]  i_evt_a,
  input  wire logic [7:0]  i_evt_b,
  input  wire logic        i_wol_evt,
  // Shared interrupt or power-down pin
  input  wire logic        i_irq_pd_pin,
  output logic             o_irq_pd_pin,
  output logic             o_irq_pd_pin_oe_n,
  // Internal status
  output logic             o_irq_req,
  output logic             o_powerdown_req
);
  pei_pkg::pei_wr_t wr;
  pei_pkg::pei_rd_t rd;
  logic [15:0]      ctl_q;
  logic [15:0]      ctl_d;
  logic [7:0]       pend_a_q;
  logic [7:0]       pend_a_d;
  logic [7:0]       en_a_q;
  logic [7:0]       en_a_d;
  logic [7:0]       pend_b_q;
  logic [7:0]       pend_b_d;
  logic [7:0]       en_b_q;
  logic [7:0]       en_b_d;
  logic             irq_q;
  logic             pin_q;
  logic             oe_n_q;
  logic             pd_q;

  // Word decode of a byte address
  function automatic logic at_idx(input logic [11:0] addr, input logic [5:0] idx);
    at_idx = (addr[11:8] == 4'h0) && (addr[7:2] == idx);
  endfunction

  // Write decode
  wire wr_ctl = wr.en & at_idx(wr.addr, `PEI_IDX_CTL);
  wire wr_a = wr.en & at_idx(wr.addr, `PEI_IDX_A);
  wire wr_b = wr.en & at_idx(wr.addr, `PEI_IDX_B);
  wire wr_hit = wr_ctl | wr_a | wr_b;
  wire [15:0] wdata16 = wr.data[15:0];
  wire [15:0] lane16 = {{8{wr.strb[1]}}, {8{wr.strb[0]}}};
  wire [15:0] ctl_wmask = `PEI_CTL_WMASK & lane16;

  // Read decode
  wire rd_ctl = rd.en & at_idx(rd.addr, `PEI_IDX_CTL);
  wire rd_a = rd.en & at_idx(rd.addr, `PEI_IDX_A);
  wire rd_b = rd.en & at_idx(rd.addr, `PEI_IDX_B);
  wire rd_hit = rd_ctl | rd_a | rd_b;

  // Read data, sixteen bits in the low half
  wire [15:0] reg_a = {pend_a_q, en_a_q};
  wire [15:0] reg_b = {pend_b_q, en_b_q};
  wire [15:0] rd_sel = rd_a ? reg_a : rd_b ? reg_b : rd_ctl ? ctl_q : 16'h0000;
  wire [31:0] rd_data = {16'h0000, rd_sel};

  // Event vectors; polarity and wake share one flag
  wire [7:0] evt_a = i_evt_a;
  wire [7:0] evt_b = i_evt_b | (i_wol_evt ? (8'h01 << `PEI_B_POLWOL) : 8'h00); // RULE16

  // Control register
  assign ctl_d = wr_ctl ? ((ctl_q & ~ctl_wmask) | (wdata16 & ctl_wmask)) : ctl_q;

  // Enable bytes
  assign en_a_d = (wr_a & wr.strb[0]) ? wdata16[7:0] : en_a_q; // RULE9
  assign en_b_d = (wr_b & wr.strb[0]) ? wdata16[7:0] : en_b_q; // RULE18

  // Pending bytes: read clears what it returns, a new event wins
  assign pend_a_d = (pend_a_q & ~{8{rd_a}}) | evt_a; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE25
  assign pend_b_d = (pend_b_q & ~{8{rd_b}}) | evt_b; // RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE17 RULE25

  // Interrupt request
  wire [7:0] hit_a = pend_a_q & en_a_q; // RULE9
  wire [7:0] hit_b = pend_b_q & en_b_q; // RULE18
  wire evt_irq = ctl_q[`PEI_CTL_MIE] & (|hit_a | |hit_b); // RULE20 RULE24
  wire irq_act = evt_irq | ctl_q[`PEI_CTL_TEST]; // RULE23
  wire pol_sel = ctl_q[`PEI_CTL_POL];
  wire pin_lvl = irq_act ^ pol_sel; // RULE21
  wire pin_is_irq = ctl_q[`PEI_CTL_OUTEN];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= `PEI_CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {pend_a_q, en_a_q} <= `PEI_EVT_RST;
    end else begin
      pend_a_q <= pend_a_d;
      en_a_q   <= en_a_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {pend_b_q, en_b_q} <= `PEI_EVT_RST; // RULE19
    end else begin
      pend_b_q <= pend_b_d;
      en_b_q   <= en_b_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q  <= 1'b0;
      pin_q  <= 1'b1;
      oe_n_q <= 1'b1;
      pd_q   <= 1'b0;
    end else begin
      irq_q  <= irq_act; // RULE24
      pin_q  <= pin_lvl; // RULE21
      oe_n_q <= ~pin_is_irq; // RULE22
      pd_q   <= ~pin_is_irq & ~i_irq_pd_pin; // RULE22
    end
  end

  assign o_irq_req = irq_q;
  assign o_irq_pd_pin = pin_q;
  assign o_irq_pd_pin_oe_n = oe_n_q;
  assign o_powerdown_req = pd_q;

  // Bus front end
  pei_axil_slave u_axil (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .o_wr          (wr),
    .o_rd          (rd),
    .i_wr_err      (~wr_hit),
    .i_rd_data     (rd_data),
    .i_rd_err      (~rd_hit)
  );

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_evt_a_latch: assert property ( // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
    (evt_a != 8'h00) |=> ((pend_a_q & $past(evt_a)) == $past(evt_a))
  ) else $error("first register event not latched");

  a_evt_b_latch: assert property ( // RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE17
    (i_evt_b != 8'h00) |=> ((pend_b_q & $past(i_evt_b)) == $past(i_evt_b))
  ) else $error("second register event not latched");

  a_wol_shared: assert property ( // RULE16
    i_wol_evt |=> pend_b_q[`PEI_B_POLWOL]
  ) else $error("wake packet did not set shared flag");

  a_read_clear: assert property ( // RULE25
    rd_a |=> (pend_a_q == $past(evt_a)) ##0 (s_axi_rdata[15:8] == $past(pend_a_q))
  ) else $error("read did not clear exactly the returned bits");

  a_read_clear_b: assert property ( // RULE25
    (rd_b && evt_b == 8'h00) |=> (pend_b_q == 8'h00) && s_axi_rvalid
  ) else $error("second register read did not clear");

  a_enable_write: assert property ( // RULE9
    (wr_a && wr.strb[0]) |=> (en_a_q == 8'($past(wdata16))) && s_axi_bvalid
  ) else $error("enable byte not written");

  a_master_gate: assert property ( // RULE20
    (!ctl_q[`PEI_CTL_MIE] && !ctl_q[`PEI_CTL_TEST]) |=> !o_irq_req
  ) else $error("interrupt without master enable");

  a_irq_cause: assert property ( // RULE24
    (ctl_q[`PEI_CTL_MIE] && ((hit_a | hit_b) != 8'h00)) |=> o_irq_req
  ) else $error("enabled pending event gave no request");

  a_test_irq: assert property ( // RULE23
    ctl_q[`PEI_CTL_TEST] [*2] |=> o_irq_req && (o_irq_pd_pin != $past(pol_sel))
  ) else $error("test interrupt not held");

  a_pin_dir: assert property ( // RULE22 RULE21
    !ctl_q[`PEI_CTL_OUTEN] |=> o_irq_pd_pin_oe_n && (o_irq_pd_pin == ($past(irq_act) ^ $past(pol_sel)))
  ) else $error("pin direction or level wrong");

  a_quality_latch: assert property ( // RULE1
    evt_a[`PEI_A_LQ] |=> pend_a_q[`PEI_A_LQ]
  ) else $error("link quality event lost");

  a_energy_latch: assert property ( // RULE2
    evt_a[`PEI_A_ED] |=> pend_a_q[`PEI_A_ED]
  ) else $error("energy detect event lost");

  a_link_latch: assert property ( // RULE3
    evt_a[`PEI_A_LINK] |=> pend_a_q[`PEI_A_LINK]
  ) else $error("link status event lost");

  a_speed_latch: assert property ( // RULE4
    evt_a[`PEI_A_SPEED] |=> pend_a_q[`PEI_A_SPEED]
  ) else $error("speed event lost");

  a_duplex_latch: assert property ( // RULE5
    evt_a[`PEI_A_DUPLEX] |=> pend_a_q[`PEI_A_DUPLEX]
  ) else $error("duplex event lost");

  a_negdone_latch: assert property ( // RULE6
    evt_a[`PEI_A_ANDONE] |=> pend_a_q[`PEI_A_ANDONE]
  ) else $error("negotiation done event lost");

  a_carrier_latch: assert property ( // RULE7
    evt_a[`PEI_A_FCHF] |=> pend_a_q[`PEI_A_FCHF]
  ) else $error("false carrier event lost");

  a_rxerr_latch: assert property ( // RULE8
    evt_a[`PEI_A_REHF] |=> pend_a_q[`PEI_A_REHF]
  ) else $error("receive error event lost");

  a_eee_latch: assert property ( // RULE10
    i_evt_b[`PEI_B_EEE] |=> pend_b_q[`PEI_B_EEE]
  ) else $error("efficient ethernet error lost");

  a_negerr_latch: assert property ( // RULE11
    i_evt_b[`PEI_B_ANERR] |=> pend_b_q[`PEI_B_ANERR]
  ) else $error("negotiation error lost");

  a_page_latch: assert property ( // RULE12
    i_evt_b[`PEI_B_PAGE] |=> pend_b_q[`PEI_B_PAGE]
  ) else $error("page event lost");

  a_loopfifo_latch: assert property ( // RULE13
    i_evt_b[`PEI_B_LOOPF] |=> pend_b_q[`PEI_B_LOOPF]
  ) else $error("loopback fifo event lost");

  a_crossover_latch: assert property ( // RULE14
    i_evt_b[`PEI_B_MDIX] |=> pend_b_q[`PEI_B_MDIX]
  ) else $error("crossover event lost");

  a_sleep_latch: assert property ( // RULE15
    i_evt_b[`PEI_B_SLEEP] |=> pend_b_q[`PEI_B_SLEEP]
  ) else $error("sleep event lost");

  a_polarity_latch: assert property ( // RULE16
    i_evt_b[`PEI_B_POLWOL] |=> pend_b_q[`PEI_B_POLWOL]
  ) else $error("polarity event lost");

  a_jabber_latch: assert property ( // RULE17
    i_evt_b[`PEI_B_JABBER] |=> pend_b_q[`PEI_B_JABBER]
  ) else $error("jabber event lost");

  a_enable_b: assert property ( // RULE18
    (wr_b && wr.strb[0]) |=> (en_b_q == 8'($past(wdata16))) && s_axi_bvalid
  ) else $error("second enable byte not written");

  a_read_b_data: assert property ( // RULE18
    rd_b |=> (s_axi_rdata[31:16] == 16'h0000) && (s_axi_rdata[7:0] == $past(en_b_q))
  ) else $error("second register read data wrong");

  a_unmapped_rd: assert property ( // RULE19
    (rd.en && !rd_hit) |=> (s_axi_rresp == `PEI_RESP_SLV) && (s_axi_rdata == 32'h0000_0000)
  ) else $error("unmapped read not refused");

  a_unmapped_wr: assert property ( // RULE19
    (wr.en && !wr_hit) |=> (s_axi_bresp == `PEI_RESP_SLV) && $stable(ctl_q) && $stable(en_a_q) && $stable(en_b_q)
  ) else $error("unmapped write not refused");

  a_pin_drive: assert property ( // RULE22
    ctl_q[`PEI_CTL_OUTEN] |=> !o_irq_pd_pin_oe_n
  ) else $error("pin not driven as interrupt output");

  a_powerdown_in: assert property ( // RULE22
    (!ctl_q[`PEI_CTL_OUTEN] && !i_irq_pd_pin) |=> o_powerdown_req
  ) else $error("power-down input not seen");

  a_irq_release: assert property ( // RULE24
    (!ctl_q[`PEI_CTL_TEST] && ((hit_a | hit_b) == 8'h00)) |=> !o_irq_req
  ) else $error("request held with nothing pending");

  a_pend_no_write: assert property ( // RULE25
    (wr_a && !rd_a && (evt_a == 8'h00)) |=> $stable(pend_a_q)
  ) else $error("write changed pending bits");

endmodule

// ---- sim/test_pei_top.sv ----
// Self-checking bench for the event status and enable registers
// Assumes pei_top and the consts header on the include path
`timescale 1ns/1ps
`include "pei_consts.svh"
module test_pei_top;
  localparam logic [11:0] A_CTL = {4'h0, `PEI_IDX_CTL, 2'b00};
  localparam logic [11:0] A_EA  = {4'h0, `PEI_IDX_A, 2'b00};
  localparam logic [11:0] A_EB  = {4'h0, `PEI_IDX_B, 2'b00};
  logic        i_core_clk = 1'b0;
  logic        i_rst_n    = 1'b0;
  logic [11:0] awaddr     = 12'h000;
  logic [11:0] araddr     = 12'h000;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic [31:0] wdata      = 32'h0;
  logic [7:0]  evt_a      = 8'h00;
  logic [7:0]  evt_b      = 8'h00;
  logic        wol        = 1'b0;
  logic        pd_pin     = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        irq_req, pd_req, pin_o, pin_oe_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] rng        = 32'hedf5bbfa;
  int          err_total  = 0;
  int          samples_checked = 0;
  // Behavioural model state
  int          pa = 0, pb = 0, ea = 0, eb = 0, ctl = 'h108;

  always #20 i_core_clk = ~i_core_clk;

  pei_top u_dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .i_evt_a(evt_a), .i_evt_b(evt_b), .i_wol_evt(wol),
    .i_irq_pd_pin(pd_pin), .o_irq_pd_pin(pin_o), .o_irq_pd_pin_oe_n(pin_oe_n),
    .o_irq_req(irq_req), .o_powerdown_req(pd_req)
  );

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_pin(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_core_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  // Event mask ev is pulsed on the same edge that raises the read address
  task automatic rd(input logic [11:0] a, input logic [7:0] ev, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    evt_a   <= ev;
    do begin
      @(posedge i_core_clk);
      n++;
      evt_a <= 8'h00;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] ev);
    logic [31:0] d, e;
    logic [1:0]  r;
    rd(a, ev, d, r);
    e = (a == A_CTL) ? 32'(ctl) : (a == A_EA) ? 32'(pa << 8 | ea) : (a == A_EB) ? 32'(pb << 8 | eb) : 32'h0;
    chk_reg("rdata", e, d);
    chk_reg("rresp", (a inside {A_CTL, A_EA, A_EB}) ? `PEI_RESP_OKAY : `PEI_RESP_SLV, 32'(r));
    pa = (a == A_EA) ? int'(ev) : pa | ev;
    if (a == A_EB) pb = 0;
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk_reg("bresp", (a inside {A_CTL, A_EA, A_EB}) ? `PEI_RESP_OKAY : `PEI_RESP_SLV, 32'(r));
    if (a == A_CTL) ctl = d & `PEI_CTL_WMASK;
    if (a == A_EA) ea = d & 8'hff;
    if (a == A_EB) eb = d & 8'hff;
  endtask

  task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic w);
    @(posedge i_core_clk);
    evt_a <= a;
    evt_b <= b;
    wol   <= w;
    @(posedge i_core_clk);
    evt_a <= 8'h00;
    evt_b <= 8'h00;
    wol   <= 1'b0;
    pa = pa | a;
    pb = pb | b | (w << 1);
  endtask

  // Pending to request and pending to pin, each one registered stage
  task automatic chk_irq();
    logic e;
    repeat (3) @(posedge i_core_clk);
    e = ctl[2] | (ctl[1] & (((pa & ea) | (pb & eb)) != 0));
    chk_pin("irq_req", e, irq_req);
    chk_pin("pin_oe_n", !ctl[0], pin_oe_n);
    if (ctl[0]) chk_pin("pin_out", e ^ ctl[3], pin_o);
    chk_pin("powerdown", !ctl[0] && !pd_pin, pd_req);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_total++;
    end_of_test();
  end

  initial begin
    logic [31:0] v;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    // Reset values and map
    chk_irq();
    rd_chk(A_CTL, 8'h00);
    rd_chk(A_EA, 8'h00);
    rd_chk(A_EB, 8'h00);
    rd_chk(12'h040, 8'h00);
    wr_chk(12'h050, 32'hffffffff);
    rd_chk(A_EB, 8'h00);
    $display("test reset_map done");
    // Each event latches, clears on read, enables stay
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      wr_chk(A_EA, v);
      wr_chk(A_EB, v >> 8);
      if (i < 8) pulse(8'h01 << i, 8'h00, 1'b0);
      else pulse(8'h00, 8'h01 << (i - 8), 1'b0);
      rd_chk(A_EA, 8'h00);
      rd_chk(A_EB, 8'h00);
      rd_chk(A_EA, 8'h00);
      rd_chk(A_EB, 8'h00);
    end
    pulse(8'h00, 8'h00, 1'b1);
    rd_chk(A_EB, 8'h00);
    pulse(8'h80, 8'h00, 1'b0);
    rd_chk(A_EA, 8'h04);
    rd_chk(A_EA, 8'h00);
    $display("test latch_clear done");
    // Request gating, test bit, polarity and pin mode
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      pd_pin <= v[31];
      wr_chk(A_EA, v);
      wr_chk(A_EB, v >> 8);
      wr_chk(A_CTL, (k < 2) ? {28'h0, k[0], 3'b001} : rnd());
      pulse(8'(rnd()), 8'(rnd()), v[30]);
      chk_irq();
      rd_chk(A_EA, 8'h00);
      chk_irq();
      rd_chk(A_EB, 8'h00);
      chk_irq();
      rd_chk(A_CTL, 8'h00);
    end
    $display("test irq_pin done");
    end_of_test();
  end
endmodule
